// *** status_area_map.svh ***
// Address map, field positions, reset values and timing counts of the status area
// Behaviour
// - Area occupies words 236 to 255.
// - Flags read zero until their condition.
// - Restart bit set then cleared restarts unit.
// - Control bits stay zero until software sets.
// - Word 254 drives minute and 20ms pulses.
// - Word 255 drives 0.1, 0.2, 1.0s pulses.
// - Word 253 low byte holds fault alarm number.
// - Word 253 bit 9 marks cycle time error.
// - Word 253 bit 10 marks I/O verify error.
// - Word 255 bits 3-7 carry result flags.
// - Word 254 bit 15 marks special unit error.
// - Reserved bits of word 254 read zero.
// - Word 252 holds forced, I/O hold, outputs-off.
// - Completion codes written into word 237 per level.
// - Word 236 reports loop status per level.
// - Word 251 holds remote I/O error flags.
// - Word 252 bits 1 and 4 enable transfers.
// - Toggling error-check bit shows next stored error.
`ifndef STATUS_AREA_MAP_SVH
`define STATUS_AREA_MAP_SVH

// ****************************************
// Word addresses
// ****************************************
`define ADDR_LOOP_STATUS 8'hEC
`define ADDR_COMPLETION 8'hED
`define ADDR_L0_LINK_FIRST 8'hEE
`define ADDR_L1_LINK_FIRST 8'hF2
`define ADDR_RUN_ERR_FIRST 8'hF7
`define ADDR_REMOTE_IO 8'hFB
`define ADDR_LINK_CTRL 8'hFC
`define ADDR_SYS_ERROR 8'hFD
`define ADDR_SLOW_PULSE 8'hFE
`define ADDR_PULSE_RESULT 8'hFF
`define ADDR_IRQ_STATUS 8'hE0
`define ADDR_IRQ_ENABLE 8'hE1
`define ADDR_IRQ_CLEAR 8'hE2

// ****************************************
// Field positions
// ****************************************
`define BIT_RIO_CHECK 0
`define BIT_RIO_FLAG 3
`define BIT_L0_ENABLE 1
`define BIT_L1_ENABLE 4
`define BIT_L1_RESTART 7
`define BIT_CPU_RESTART 9
`define BIT_FORCE_HOLD 11
`define BIT_IO_HOLD 12
`define BIT_L0_RESTART 13
`define BIT_OUT_OFF 15
`define LINK_CTRL_WMASK 16'hBA92
`define BIT_CYCLE_ERR 9
`define BIT_VERIFY_ERR 10
`define BIT_SPECIAL_ERR 15
`define RESET_WORD 16'h0000

// ****************************************
// Pulse timing at 100 MHz, half periods
// ****************************************
`define CLK_HZ 100000000
`define HALF_MIN_CYC (36'(`CLK_HZ) * 30)
`define HALF_20MS_CYC (`CLK_HZ / 100)
`define HALF_100MS_CYC (`CLK_HZ / 20)
`define HALF_200MS_CYC (`CLK_HZ / 10)
`define HALF_1S_CYC (`CLK_HZ / 2)

`endif

// *** status_area_pkg.sv ***
// Types shared by the status area bank
package status_area_pkg;
    // Result flags of an executed instruction
    typedef struct packed {
        logic less;
        logic equal;
        logic greater;
        logic carry;
        logic exec_err;
    } result_flags_s;

    // Completion report of a transfer instruction
    typedef struct packed {
        logic valid;
        logic level;
        logic [7:0] code;
    } completion_s;

    // Remote I/O error queue state
    typedef enum logic [0:0] {RIO_IDLE, RIO_SHOWN} rio_state_e;
endpackage

// *** special_status_area.sv ***
// Special status area: pulse bits, error flags, control bits and link status words
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "status_area_map.svh"

module special_status_area
    import status_area_pkg::*;
#(
    parameter longint HALF_MIN = `HALF_MIN_CYC,
    parameter int HALF_20MS = `HALF_20MS_CYC,
    parameter int HALF_100MS = `HALF_100MS_CYC,
    parameter int HALF_200MS = `HALF_200MS_CYC,
    parameter int HALF_1S = `HALF_1S_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // Status sources from the CPU core
    input wire logic [7:0] fault_alarm_number_i,
    input wire logic fault_alarm_valid_i,
    input wire logic cycle_err_i,
    input wire logic verify_err_i,
    input wire logic special_err_i,
    input wire result_flags_s result_i,
    input wire logic result_valid_i,
    input wire completion_s completion_i,
    input wire logic [15:0] loop_status_i,
    input wire logic [63:0] l0_link_i,
    input wire logic [63:0] l1_link_i,
    input wire logic [63:0] run_err_i,
    // Remote I/O error entry from the queue
    input wire logic [15:0] rio_entry_i,
    input wire logic rio_entry_valid_i,
    output logic rio_next_o,
    // Control outputs
    output logic [2:0] restart_o,
    output logic force_hold_o,
    output logic io_hold_o,
    output logic out_off_o,
    output logic [1:0] xfer_enable_o,
    output logic irq_o
);

    // ****************************************
    // Reset release
    // ****************************************
    logic rst_s1, rst_n;
    // Two stage release keeps deassertion synchronous
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // ****************************************
    // Clock pulse generators
    // ****************************************
    logic [4:0] pulse; // Bit 0 minute, 1 20ms, 2 0.1s, 3 0.2s, 4 1s
    logic [35:0] pcnt [5]; // Half period counters
    logic [35:0] half [5];
    assign half[0] = 36'(HALF_MIN);
    assign half[1] = 36'(HALF_20MS);
    assign half[2] = 36'(HALF_100MS);
    assign half[3] = 36'(HALF_200MS);
    assign half[4] = 36'(HALF_1S);

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_pulse
            // Toggle every half period gives an even square wave
            always_ff @(posedge sys_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    pcnt[g] <= 36'h0;
                    pulse[g] <= 1'b0;
                end else if (pcnt[g] >= half[g] - 36'h1) begin
                    pcnt[g] <= 36'h0;
                    pulse[g] <= ~pulse[g];
                end else begin
                    pcnt[g] <= pcnt[g] + 36'h1;
                end
            end
        end
    endgenerate

    // ****************************************
    // System error and result flags
    // ****************************************
    logic [7:0] fault_alarm_number; // Latest alarm number
    logic cycle_err, verify_err, special_err; // Sticky error flags
    result_flags_s result; // Last result flags
    logic first_cycle; // High in the first cycle after reset

    // Error flags start at zero and latch on their condition
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fault_alarm_number <= 8'h00;
            cycle_err <= 1'b0;
            verify_err <= 1'b0;
            special_err <= 1'b0;
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
            if (fault_alarm_valid_i) begin
                fault_alarm_number <= fault_alarm_number_i;
            end
            if (cycle_err_i) begin
                cycle_err <= 1'b1;
            end
            if (verify_err_i) begin
                verify_err <= 1'b1;
            end
            if (special_err_i) begin
                special_err <= 1'b1;
            end
        end
    end

    // Result flags follow each executed instruction
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            result <= '0;
        end else if (result_valid_i) begin
            result <= result_i;
        end
    end

    // ****************************************
    // Link status words
    // ****************************************
    logic [15:0] loop_status, completion;
    // Completion codes replace only the byte of their level
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            loop_status <= `RESET_WORD;
            completion <= `RESET_WORD;
        end else begin
            loop_status <= loop_status_i;
            if (completion_i.valid && !completion_i.level) begin
                completion[7:0] <= completion_i.code;
            end
            if (completion_i.valid && completion_i.level) begin
                completion[15:8] <= completion_i.code;
            end
        end
    end

    // ****************************************
    // Remote I/O error word
    // ****************************************
    logic [15:0] rio_word; // Shown error entry
    logic rio_check; // Error check bit written by software
    rio_state_e rio_state;
    // A falling check bit retires the shown entry and asks for the next
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rio_word <= `RESET_WORD;
            rio_state <= RIO_IDLE;
            rio_next_o <= 1'b0;
        end else begin
            rio_next_o <= 1'b0;
            case (rio_state)
                RIO_IDLE: begin
                    if (rio_entry_valid_i && !rio_next_o) begin // Source not yet moved on
                        rio_word <= rio_entry_i;
                        rio_word[`BIT_RIO_FLAG] <= 1'b1;
                        rio_state <= RIO_SHOWN;
                    end
                end
                default: begin
                    if (wr_i && addr_i == `ADDR_REMOTE_IO && rio_check
                        && !wdata_i[`BIT_RIO_CHECK]) begin
                        rio_next_o <= 1'b1;
                        rio_word <= `RESET_WORD;
                        rio_state <= RIO_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Control word
    // ****************************************
    logic [15:0] link_ctrl; // Software written control bits
    logic [2:0] restart_prev;
    // Only documented control positions accept writes
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            link_ctrl <= `RESET_WORD;
            rio_check <= 1'b0;
        end else if (wr_i) begin
            if (addr_i == `ADDR_LINK_CTRL) begin
                link_ctrl <= wdata_i & `LINK_CTRL_WMASK;
            end else if (addr_i == `ADDR_REMOTE_IO) begin
                rio_check <= wdata_i[`BIT_RIO_CHECK];
            end
        end
    end

    logic [2:0] restart_now;
    assign restart_now = {link_ctrl[`BIT_CPU_RESTART], link_ctrl[`BIT_L1_RESTART],
        link_ctrl[`BIT_L0_RESTART]};
    // Restart fires on the falling edge of each restart bit
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            restart_prev <= 3'h0;
            restart_o <= 3'h0;
        end else begin
            restart_prev <= restart_now;
            restart_o <= restart_prev & ~restart_now;
        end
    end

    assign force_hold_o = link_ctrl[`BIT_FORCE_HOLD];
    assign io_hold_o = link_ctrl[`BIT_IO_HOLD];
    assign out_off_o = link_ctrl[`BIT_OUT_OFF];
    assign xfer_enable_o = {link_ctrl[`BIT_L1_ENABLE], link_ctrl[`BIT_L0_ENABLE]};

    // ****************************************
    // Word assembly
    // ****************************************
    logic [15:0] sys_err_word, slow_word, pulse_word;
    assign sys_err_word = {first_cycle, 1'b0, 1'b1, 2'b00, verify_err, cycle_err, 1'b0,
        fault_alarm_number};
    assign slow_word = {special_err, 13'h0000, pulse[1], pulse[0]};
    assign pulse_word = {8'h00, result, pulse[4], pulse[3], pulse[2]};

    // ****************************************
    // Interrupt: bit0 cycle, 1 verify, 2 special, 3 remote I/O
    // ****************************************
    logic [3:0] irq_status, irq_enable, irq_event;
    assign irq_event = {rio_state == RIO_IDLE && rio_entry_valid_i && !rio_next_o,
        special_err_i, verify_err_i, cycle_err_i};
    // Set wins over a clear in the same cycle
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= 4'h0;
            irq_enable <= 4'h0;
        end else begin
            if (wr_i && addr_i == `ADDR_IRQ_ENABLE) begin
                irq_enable <= wdata_i[3:0];
            end
            if (wr_i && addr_i == `ADDR_IRQ_CLEAR) begin
                irq_status <= (irq_status & ~wdata_i[3:0]) | irq_event;
            end else begin
                irq_status <= irq_status | irq_event;
            end
        end
    end
    assign irq_o = |(irq_status & irq_enable);

    // ****************************************
    // Read decode
    // ****************************************
    function automatic logic [15:0] pick4(input logic [63:0] blk, input logic [7:0] off);
        pick4 = blk[16 * off[1:0] +: 16];
    endfunction

    logic [15:0] next_rdata;
    // Unmapped addresses read zero
    always_comb begin
        next_rdata = 16'h0000;
        if (addr_i == `ADDR_LOOP_STATUS) begin
            next_rdata = loop_status;
        end else if (addr_i == `ADDR_COMPLETION) begin
            next_rdata = completion;
        end else if (addr_i >= `ADDR_L0_LINK_FIRST && addr_i < `ADDR_L1_LINK_FIRST) begin
            next_rdata = pick4(l0_link_i, addr_i - `ADDR_L0_LINK_FIRST);
        end else if (addr_i >= `ADDR_L1_LINK_FIRST && addr_i < 8'hF6) begin
            next_rdata = pick4(l1_link_i, addr_i - `ADDR_L1_LINK_FIRST);
        end else if (addr_i >= `ADDR_RUN_ERR_FIRST && addr_i < `ADDR_REMOTE_IO) begin
            next_rdata = pick4(run_err_i, addr_i - `ADDR_RUN_ERR_FIRST);
        end else if (addr_i == `ADDR_REMOTE_IO) begin
            next_rdata = {rio_word[15:1], rio_check};
        end else if (addr_i == `ADDR_LINK_CTRL) begin
            next_rdata = link_ctrl;
        end else if (addr_i == `ADDR_SYS_ERROR) begin
            next_rdata = sys_err_word;
        end else if (addr_i == `ADDR_SLOW_PULSE) begin
            next_rdata = slow_word;
        end else if (addr_i == `ADDR_PULSE_RESULT) begin
            next_rdata = pulse_word;
        end else if (addr_i == `ADDR_IRQ_STATUS) begin
            next_rdata = {12'h000, irq_status};
        end else if (addr_i == `ADDR_IRQ_ENABLE) begin
            next_rdata = {12'h000, irq_enable};
        end
    end

    // Read data stand one cycle after the strobe only
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rd_i ? next_rdata : 16'h0000;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_restart;
        @(posedge sys_clk_i) disable iff (!rst_n)
        $fell(restart_now[0]) |=> restart_o[0];
    endproperty
    a_restart: assert property (p_restart) else $error("restart missed");

    property p_ctrl_reset;
        @(posedge sys_clk_i) disable iff (!rst_n)
        $rose(rst_n) |-> link_ctrl == 16'h0000;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not zero");

    property p_fast_pulse;
        @(posedge sys_clk_i) disable iff (!rst_n)
        $changed(pulse[2]) |-> $past(pcnt[2]) == half[2] - 36'h1;
    endproperty
    a_fast_pulse: assert property (p_fast_pulse) else $error("pulse toggled off count");

    property p_alarm;
        @(posedge sys_clk_i) disable iff (!rst_n)
        fault_alarm_valid_i |=> fault_alarm_number == $past(fault_alarm_number_i);
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm number wrong");

    property p_cycle_err;
        @(posedge sys_clk_i) disable iff (!rst_n)
        cycle_err_i |=> sys_err_word[`BIT_CYCLE_ERR] && irq_status[0];
    endproperty
    a_cycle_err: assert property (p_cycle_err) else $error("cycle error lost");

    property p_verify;
        @(posedge sys_clk_i) disable iff (!rst_n)
        verify_err_i |=> sys_err_word[`BIT_VERIFY_ERR];
    endproperty
    a_verify: assert property (p_verify) else $error("verify error lost");

    property p_result;
        @(posedge sys_clk_i) disable iff (!rst_n)
        result_valid_i |=> pulse_word[7:3] == $past(result_i);
    endproperty
    a_result: assert property (p_result) else $error("result flags wrong");

    property p_special;
        @(posedge sys_clk_i) disable iff (!rst_n)
        special_err_i |=> slow_word[`BIT_SPECIAL_ERR];
    endproperty
    a_special: assert property (p_special) else $error("special error lost");

    property p_reserved;
        @(posedge sys_clk_i) disable iff (!rst_n)
        slow_word[14:2] == 13'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    property p_completion;
        @(posedge sys_clk_i) disable iff (!rst_n)
        completion_i.valid && !completion_i.level |=> completion[7:0] == $past(completion_i.code);
    endproperty
    a_completion: assert property (p_completion) else $error("code not stored");

    c_restart: cover property (@(posedge sys_clk_i) disable iff (!rst_n) restart_o != 3'h0);
    c_rio_next: cover property (@(posedge sys_clk_i) disable iff (!rst_n) rio_next_o);
    c_irq: cover property (@(posedge sys_clk_i) disable iff (!rst_n) irq_o);

endmodule // special_status_area
`default_nettype wire

// *** rio_error_source.sv ***
// Partner model: remote I/O error queue feeding stored entries to the status area
`timescale 1ns/10ps
`default_nettype none

module rio_error_source (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Queue handshake
    input wire logic next_i,
    output logic [15:0] entry_o,
    output logic valid_o
);
    // ****************************************
    // Stored entries
    // ****************************************
    // Entries already carry the error flag bit
    localparam logic [15:0] ENTRY0 = 16'hB018;
    localparam logic [15:0] ENTRY1 = 16'h0508;
    logic [1:0] head; // Index of presented entry

    // Retire pulse moves on to the next stored error
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            head <= 2'h0;
        end else if (next_i && head != 2'h2) begin
            head <= head + 2'h1;
        end
    end

    // Drained queue shows inverted stale data, so a late sample is caught
    always_comb begin
        valid_o = (head != 2'h2);
        entry_o = (head == 2'h0) ? ENTRY0 : (head == 2'h1) ? ENTRY1 : ~ENTRY1;
    end
endmodule // rio_error_source

`default_nettype wire

// *** special_status_area_test.sv ***
// Self-checking bench for the special status area
`timescale 1ns/10ps
`default_nettype none

module special_status_area_test;
    import status_area_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic clk = 1'b0; // 100 MHz
    logic rst_n = 1'b0; // Active low reset
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [7:0] alarm_num = 8'h00;
    logic alarm_valid = 1'b0;
    logic [15:0] loop_st = 16'hA5C3; // Loop status source
    logic [63:0] l0_link = 64'h4444_3333_2222_1111;
    logic [63:0] l1_link = 64'h8888_7777_6666_5555;
    logic [63:0] run_err = 64'hDDDD_CCCC_BBBB_AAAA;
    logic cyc_err = 1'b0;
    logic ver_err = 1'b0;
    logic spc_err = 1'b0;
    result_flags_s result = '0;
    logic result_valid = 1'b0;
    completion_s compl = '0;
    logic [15:0] rio_entry;
    logic rio_valid;
    logic rio_next;
    logic [2:0] restart;
    logic force_hold;
    logic io_hold;
    logic out_off;
    logic [1:0] xfer_en;
    logic irq;
    int mismatches = 0;
    int compares = 0;

    // Table row: address, write flag, write data, expected read
    typedef struct packed {
        logic [7:0] a;
        logic w;
        logic [15:0] d;
        logic [15:0] e;
    } row_s;
    row_s rows [0:11] = '{
        '{8'hE1, 1'b1, 16'h000F, 16'h000F}, '{8'hFD, 1'b1, 16'hFFFF, 16'h2000},
        '{8'hFC, 1'b1, 16'hFFFF, 16'hBA92}, '{8'hFC, 1'b1, 16'h0000, 16'h0000},
        '{8'hEC, 1'b0, 16'h0000, 16'hA5C3}, '{8'hEE, 1'b0, 16'h0000, 16'h1111},
        '{8'hF1, 1'b0, 16'h0000, 16'h4444}, '{8'hF2, 1'b0, 16'h0000, 16'h5555},
        '{8'hF5, 1'b0, 16'h0000, 16'h8888}, '{8'hFA, 1'b0, 16'h0000, 16'hDDDD},
        '{8'hF6, 1'b0, 16'h0000, 16'h0000}, '{8'h80, 1'b0, 16'h0000, 16'h0000}
    };
    // Pulse bits: word, bit, half period in cycles
    logic [7:0] p_addr [0:4] = '{8'hFE, 8'hFE, 8'hFF, 8'hFF, 8'hFF};
    int p_bit [0:4] = '{0, 1, 0, 1, 2};
    int p_half [0:4] = '{10, 2, 3, 4, 5};

    always #5 clk = ~clk;

    // Short half periods keep the minute pulse within a short run
    special_status_area #(.HALF_MIN(10), .HALF_20MS(2), .HALF_100MS(3), .HALF_200MS(4),
        .HALF_1S(5)) u_special_status_area (
        .sys_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .fault_alarm_number_i(alarm_num),
        .fault_alarm_valid_i(alarm_valid), .cycle_err_i(cyc_err), .verify_err_i(ver_err),
        .special_err_i(spc_err), .result_i(result), .result_valid_i(result_valid),
        .completion_i(compl), .loop_status_i(loop_st),
        .l0_link_i(l0_link), .l1_link_i(l1_link),
        .run_err_i(run_err), .rio_entry_i(rio_entry),
        .rio_entry_valid_i(rio_valid), .rio_next_o(rio_next), .restart_o(restart),
        .force_hold_o(force_hold), .io_hold_o(io_hold), .out_off_o(out_off),
        .xfer_enable_o(xfer_en), .irq_o(irq));

    rio_error_source u_rio_error_source (.clk_i(clk), .rst_n_i(rst_n), .next_i(rio_next),
        .entry_o(rio_entry), .valid_o(rio_valid));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One-cycle write strobe
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Bounded wait: 0 restart pulse, 1 retire pulse, 2 interrupt
    task automatic wait_until(input int sel, input int limit);
        int n;
        n = 0;
        #1;
        while (!((sel == 0 && restart !== 3'b000) || (sel == 1 && rio_next === 1'b1)
                || (sel == 2 && irq === 1'b1))) begin
            @(posedge clk);
            #1;
            n++;
            if (n > limit) begin
                mismatches++;
                $display("wrong value wait %0d expected event seen timeout", sel);
                summarize();
            end
        end
    endtask

    // Back-to-back reads sample a pulse bit every cycle
    task automatic pulse_len(input logic [7:0] a, input int b, input int h);
        logic s [64];
        int i;
        int hi;
        int lo;
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge clk);
            #1 s[i] = rdata[b];
        end
        @(posedge clk);
        rd <= 1'b0;
        i = 1;
        while (i < 63 && !(s[i] === 1'b1 && s[i-1] === 1'b0)) begin
            i++;
        end
        hi = 0;
        while (i < 64 && s[i] === 1'b1) begin
            hi++;
            i++;
        end
        lo = 0;
        while (i < 64 && s[i] === 1'b0) begin
            lo++;
            i++;
        end
        check("pulse high", 64'(hi), 64'(h));
        check("pulse low", 64'(lo), 64'(h));
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [15:0] v;
        int i;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // Table of plain register cases
        for (i = 0; i < 12; i++) begin
            if (rows[i].w) begin
                write_reg(rows[i].a, rows[i].d);
            end
            read_reg(rows[i].a, v);
            check("table word", v, rows[i].e);
        end
        for (i = 0; i < 5; i++) begin
            pulse_len(p_addr[i], p_bit[i], p_half[i]);
        end
        read_reg(8'hFE, v);
        check("reserved bits", v & 16'h7F7C, 16'h0000);
        loop_st <= 16'h3C5A;
        read_reg(8'hEC, v);
        check("loop status", v, 16'h3C5A);
        // Restart bits set then cleared give one pulse each
        write_reg(8'hFC, 16'h2280);
        write_reg(8'hFC, 16'h0000);
        wait_until(0, 4);
        check("restart pulse", restart, 3'b111);
        @(posedge clk);
        #1 check("restart end", restart, 3'b000);
        write_reg(8'hFC, 16'h9812);
        repeat (2) @(posedge clk);
        #1 check("controls", {force_hold, io_hold, out_off, xfer_en}, 5'b11111);
        write_reg(8'hFC, 16'h0010);
        repeat (2) @(posedge clk);
        #1 check("controls", {force_hold, io_hold, out_off, xfer_en}, 5'b00010);
        // Result flags in both patterns catch a stuck or shifted bit
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            result <= (i == 0) ? 5'b10101 : 5'b01010;
            result_valid <= 1'b1;
            @(posedge clk);
            result_valid <= 1'b0;
            read_reg(8'hFF, v);
            check("result flags", v & 16'h00F8, (i == 0) ? 16'h00A8 : 16'h0050);
        end
        // Alarm number and completion codes of both levels
        @(posedge clk);
        alarm_num <= 8'h5A;
        alarm_valid <= 1'b1;
        compl <= {1'b1, 1'b0, 8'h07};
        @(posedge clk);
        alarm_valid <= 1'b0;
        compl <= {1'b1, 1'b1, 8'h09};
        @(posedge clk);
        compl <= '0;
        read_reg(8'hFD, v);
        check("alarm number", v & 16'h00FF, 16'h005A);
        read_reg(8'hED, v);
        check("completion", v, 16'h0907);
        // Remote I/O queue: toggle check bit to see next entry
        read_reg(8'hFB, v);
        check("rio first", v, 16'hB018);
        write_reg(8'hFB, 16'h0001);
        write_reg(8'hFB, 16'h0000);
        wait_until(1, 4);
        repeat (3) @(posedge clk);
        read_reg(8'hFB, v);
        check("rio next", v, 16'h0508);
        // Errors raise, clear and mask the interrupt
        write_reg(8'hE2, 16'h000F);
        repeat (2) @(posedge clk);
        #1 check("irq cleared", irq, 1'b0);
        @(posedge clk);
        cyc_err <= 1'b1;
        @(posedge clk);
        cyc_err <= 1'b0;
        wait_until(2, 4);
        read_reg(8'hE0, v);
        check("irq status", v & 16'h0007, 16'h0001);
        write_reg(8'hE2, 16'h0001);
        write_reg(8'hE1, 16'h0000);
        @(posedge clk);
        ver_err <= 1'b1;
        spc_err <= 1'b1;
        @(posedge clk);
        ver_err <= 1'b0;
        spc_err <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check("irq masked", irq, 1'b0);
        read_reg(8'hE0, v);
        check("irq status", v & 16'h0007, 16'h0006);
        read_reg(8'hFD, v);
        check("error flags", v & 16'h0600, 16'h0600);
        read_reg(8'hFE, v);
        check("unit error", v & 16'h8000, 16'h8000);
        // Mid-run reset returns flags and controls to zero
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("outputs", {restart, force_hold, io_hold, out_off, xfer_en, irq}, 9'h000);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        read_reg(8'hFC, v);
        check("controls reset", v, 16'h0000);
        read_reg(8'hFD, v);
        check("flags reset", v & 16'h06FF, 16'h0000);
        read_reg(8'hFE, v);
        check("unit reset", v & 16'h8000, 16'h0000);
        summarize();
    end
endmodule // special_status_area_test

`default_nettype wire
